// ---- design/cbag_pkg.sv ----
// Package: shared constants and carrier types for the circular/bit-reverse address generator
package cbag_pkg;

  localparam int ADDR_W = 14;  // Address and register width
  localparam int SEL_W  = 2;   // Register select width (four of each)

  // Avalon register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Mode bits
  localparam logic [7:0] OFS_STATUS = 8'h04;  // Sticky events, read clears
  localparam logic [7:0] OFS_MASK   = 8'h08;  // Interrupt mask
  localparam logic [7:0] OFS_PTR0   = 8'h10;  // First generator pointers 0..3
  localparam logic [7:0] OFS_STEP0  = 8'h20;  // First generator steps 0..3
  localparam logic [7:0] OFS_LEN0   = 8'h30;  // First generator lengths 0..3
  localparam logic [7:0] OFS_PTR4   = 8'h40;  // Second generator pointers
  localparam logic [7:0] OFS_STEP4  = 8'h50;  // Second generator steps
  localparam logic [7:0] OFS_LEN4   = 8'h60;  // Second generator lengths
  localparam logic [7:0] OFS_LAST   = 8'h70;  // Last issued addresses

  // Field positions
  localparam int CTRL_BITREV_BIT = 0;  // Bit-reverse mode of first generator
  localparam int CTRL_SPORT_BIT  = 1;  // Pointer 0 feeds serial autobuffering
  localparam int EV_WRAP_BIT     = 0;  // Serial pointer wrapped

  // Reset values
  localparam logic [ADDR_W-1:0] REG_RST  = 14'h0000;  // Register files
  localparam logic [1:0]        CTRL_RST = 2'h0;      // Mode bits cleared
  localparam logic              EV_RST   = 1'b0;      // Events clear
  localparam logic [31:0]       RD_ZERO  = 32'h0000_0000;  // Unmapped read value

  // Access request from instruction control
  typedef struct packed {
    logic             valid;  // One access this cycle
    logic             gen2;   // 0: first generator, 1: second
    logic [SEL_W-1:0] ptr;    // Pointer register select
    logic [SEL_W-1:0] step;   // Step register select
  } cbag_req_t;

  // Address bus result
  typedef struct packed {
    logic              valid;  // Address valid
    logic [ADDR_W-1:0] addr;   // Issued address
  } cbag_addr_t;

  // Bus access state
  typedef enum logic [1:0] {
    CBAG_IDLE = 2'b00,  // Waiting for request
    CBAG_ACK  = 2'b01   // Answering with waitrequest low
  } cbag_bus_t;

endpackage : cbag_pkg

// ---- design/cbag_top.sv ----
// Module: modulo and bit-reverse post-modify address generator with Avalon slave
//
// Behaviour
// R1 - Circular next equals (I+M-B) mod L plus B
// R2 - Pointer, length unsigned; step signed
// R3 - Controller keeps step magnitude below length
// R4 - Base aligned to smallest covering power of two
// R5 - Base is pointer with low n bits cleared
// R6 - All-ones step decrements, wrapping base to top
// R7 - Serial pointer wrap raises serial interrupt
// R8 - Only first generator may reverse output
// R9 - Reverse mirrors fourteen bits: out k = in 13-k
// R10 - Mode bit reverses all first-generator addresses
// R11 - Written-back pointer stays normal order
// R12 - Reversal persists until mode bit cleared
// R13 - Controller sets step to two^(14-N) for N bits
// R14 - Pointer plus selected step after each access
// R15 - Zero length gives linear update
// R16 - Four pointer, step, length registers per generator
`timescale 1ns/100ps

module cbag_top
  import cbag_pkg::*;
(
  input  wire logic        ref_clk_in,        // 250 MHz clock
  input  wire logic        srst_in,           // Synchronous reset, active high
  input  wire cbag_req_t   req_in,            // Indirect access request
  output cbag_addr_t       addr_out,          // Registered address bus
  output logic             sport_irq_out,     // Serial wrap pulse (one cycle)
  output logic             irq_out,           // Masked sticky interrupt level
  input  wire logic [7:0]  avs_address_in,    // Avalon byte address
  input  wire logic        avs_read_in,       // Avalon read
  input  wire logic        avs_write_in,      // Avalon write
  input  wire logic [31:0] avs_writedata_in,  // Avalon write data
  input  wire logic [3:0]  avs_byteenable_in, // Avalon byte enables
  output logic [31:0]      avs_readdata_out,  // Avalon read data
  output logic             avs_waitrequest_out // Avalon wait request
);

  // Register files, [0..3] first generator, [4..7] second [R16]
  logic [ADDR_W-1:0] ptr_ff  [8];   // Pointer registers
  logic [ADDR_W-1:0] step_ff [8];   // Step registers
  logic [ADDR_W-1:0] len_ff  [8];   // Length registers
  logic [ADDR_W-1:0] nxt_ptr [8];
  logic [ADDR_W-1:0] nxt_step[8];
  logic [ADDR_W-1:0] nxt_len [8];
  logic [1:0]        ctrl_ff, nxt_ctrl;       // Mode bits
  logic              stat_ff, nxt_stat;       // Sticky wrap event
  logic              mask_ff, nxt_mask;       // Interrupt mask
  logic [ADDR_W-1:0] last1_ff, nxt_last1;     // Last first-gen address
  logic [ADDR_W-1:0] last2_ff, nxt_last2;     // Last second-gen address
  cbag_addr_t        addr_ff, nxt_addr;       // Address bus register
  logic              spirq_ff, nxt_spirq;     // Serial interrupt pulse
  logic              irq_ff, nxt_irq;         // Interrupt level
  cbag_bus_t         bus_ff, nxt_bus;         // Bus state
  logic [31:0]       rdata_ff, nxt_rdata;     // Read data
  logic              wait_ff, nxt_wait;       // Wait request

  // Smallest n with 2^n >= len; len 0 or 1 gives 0 [R4]
  function automatic logic [3:0] align_bits(input logic [ADDR_W-1:0] len);
    logic [ADDR_W:0] m1;
    logic [3:0]      n;
    m1 = {1'b0, len} - 15'h0001;
    n  = 4'h0;
    for (int k = 0; k < ADDR_W; k++) begin
      if (m1[k] && len > 14'h0001) begin
        n = 4'(k + 1);
      end
    end
    return n;
  endfunction

  // Post-modify with optional modulo wrap [R1] [R2] [R14] [R15]
  function automatic logic [ADDR_W:0] post_mod(input logic [ADDR_W-1:0] ip,
                                               input logic [ADDR_W-1:0] mv,
                                               input logic [ADDR_W-1:0] ln);
    logic [ADDR_W-1:0] base, ofs, lin;
    logic [ADDR_W+1:0] sum;
    logic [ADDR_W-1:0] mask;
    logic              wrap;
    mask = (14'h0001 << align_bits(ln)) - 14'h0001;
    base = ip & ~mask;                                           // [R5]
    ofs  = ip - base;
    sum  = {2'b00, ofs} + {{2{mv[ADDR_W-1]}}, mv};               // Signed step
    lin  = ip + mv;
    wrap = 1'b0;
    if (ln == 14'h0000) begin
      return {1'b0, lin};                                        // Linear [R15]
    end
    if (sum[ADDR_W+1]) begin
      sum  = sum + {2'b00, ln};                                  // Below base [R6]
      wrap = 1'b1;
    end else if (sum >= {2'b00, ln}) begin
      sum  = sum - {2'b00, ln};                                  // Past top
      wrap = 1'b1;
    end
    return {wrap, base + sum[ADDR_W-1:0]};                      // [R1]
  endfunction

  // Mirror about bits 6/7 [R9]
  function automatic logic [ADDR_W-1:0] bit_rev(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    for (int k = 0; k < ADDR_W; k++) begin
      r[k] = a[ADDR_W-1-k];
    end
    return r;
  endfunction

  // Next state of generators, registers and bus
  always_comb begin
    logic [2:0]        pi, si;
    logic [ADDR_W:0]   pm;
    logic [ADDR_W-1:0] wv;
    logic [3:0]        ri;
    pi = {req_in.gen2, req_in.ptr};
    si = {req_in.gen2, req_in.step};
    pm = post_mod(ptr_ff[pi], step_ff[si], len_ff[pi]);
    wv = avs_writedata_in[ADDR_W-1:0];
    ri = avs_address_in[7:4];
    nxt_ptr   = ptr_ff;
    nxt_step  = step_ff;
    nxt_len   = len_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_mask  = mask_ff;
    nxt_stat  = stat_ff;
    nxt_last1 = last1_ff;
    nxt_last2 = last2_ff;
    nxt_spirq = 1'b0;
    nxt_addr  = '0;
    nxt_bus   = bus_ff;
    nxt_wait  = 1'b1;
    nxt_rdata = rdata_ff;
    // Access: issue address then write back normal order
    if (req_in.valid) begin
      nxt_addr.valid = 1'b1;
      if (!req_in.gen2 && ctrl_ff[CTRL_BITREV_BIT]) begin
        nxt_addr.addr = bit_rev(ptr_ff[pi]);                     // [R8] [R10] [R12]
      end else begin
        nxt_addr.addr = ptr_ff[pi];                              // Normal order
      end
      if (req_in.gen2) begin
        nxt_last2 = nxt_addr.addr;
      end else begin
        nxt_last1 = nxt_addr.addr;
      end
      nxt_ptr[pi] = pm[ADDR_W-1:0];                              // [R11] [R14]
      if (pm[ADDR_W] && pi == 3'h0 && ctrl_ff[CTRL_SPORT_BIT]) begin
        nxt_spirq = 1'b1;                                        // [R7]
      end
    end
    // Bus slave: one wait cycle, then answer
    case (bus_ff)
      CBAG_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          nxt_bus   = CBAG_ACK;
          nxt_wait  = 1'b0;
          nxt_rdata = RD_ZERO;
          if (avs_read_in) begin
            case (ri)
              4'h0: nxt_rdata = {30'h0, ctrl_ff};
              4'h1: nxt_rdata = {16'h0, 2'b00, ptr_ff[avs_address_in[3:2]]};
              4'h2: nxt_rdata = {{18{step_ff[avs_address_in[3:2]][ADDR_W-1]}},
                                 step_ff[avs_address_in[3:2]]};
              4'h3: nxt_rdata = {18'h0, len_ff[avs_address_in[3:2]]};
              4'h4: nxt_rdata = {18'h0, ptr_ff[{1'b1, avs_address_in[3:2]}]};
              4'h5: nxt_rdata = {{18{step_ff[{1'b1, avs_address_in[3:2]}][ADDR_W-1]}},
                                 step_ff[{1'b1, avs_address_in[3:2]}]};
              4'h6: nxt_rdata = {18'h0, len_ff[{1'b1, avs_address_in[3:2]}]};
              4'h7: nxt_rdata = avs_address_in[2] ? {18'h0, last2_ff} : {18'h0, last1_ff};
              default: nxt_rdata = RD_ZERO;
            endcase
            if (avs_address_in == OFS_STATUS) begin
              nxt_rdata = {31'h0, stat_ff};
              nxt_stat  = 1'b0;                                  // Read clears
            end else if (avs_address_in == OFS_MASK) begin
              nxt_rdata = {31'h0, mask_ff};
            end
          end else if (avs_byteenable_in[0]) begin
            case (ri)
              4'h1: nxt_ptr[{1'b0, avs_address_in[3:2]}]  = wv;
              4'h2: nxt_step[{1'b0, avs_address_in[3:2]}] = wv;
              4'h3: nxt_len[{1'b0, avs_address_in[3:2]}]  = wv;
              4'h4: nxt_ptr[{1'b1, avs_address_in[3:2]}]  = wv;
              4'h5: nxt_step[{1'b1, avs_address_in[3:2]}] = wv;
              4'h6: nxt_len[{1'b1, avs_address_in[3:2]}]  = wv;
              default: begin
                if (avs_address_in == OFS_CTRL) begin
                  nxt_ctrl = avs_writedata_in[1:0];
                end else if (avs_address_in == OFS_MASK) begin
                  nxt_mask = avs_writedata_in[EV_WRAP_BIT];
                end
              end
            endcase
          end
        end
      end
      CBAG_ACK: nxt_bus = CBAG_IDLE;
      default:  nxt_bus = CBAG_IDLE;
    endcase
    if (nxt_spirq) begin
      nxt_stat = 1'b1;                                           // Set wins over clear
    end
    nxt_irq = nxt_stat & nxt_mask;
  end

  // State registers
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      for (int k = 0; k < 8; k++) begin
        ptr_ff[k]  <= REG_RST;
        step_ff[k] <= REG_RST;
        len_ff[k]  <= REG_RST;
      end
      ctrl_ff  <= CTRL_RST;
      stat_ff  <= EV_RST;
      mask_ff  <= EV_RST;
      last1_ff <= REG_RST;
      last2_ff <= REG_RST;
      addr_ff  <= '0;
      spirq_ff <= 1'b0;
      irq_ff   <= 1'b0;
      bus_ff   <= CBAG_IDLE;
      rdata_ff <= RD_ZERO;
      wait_ff  <= 1'b1;
    end else begin
      ptr_ff   <= nxt_ptr;
      step_ff  <= nxt_step;
      len_ff   <= nxt_len;
      ctrl_ff  <= nxt_ctrl;
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      last1_ff <= nxt_last1;
      last2_ff <= nxt_last2;
      addr_ff  <= nxt_addr;
      spirq_ff <= nxt_spirq;
      irq_ff   <= nxt_irq;
      bus_ff   <= nxt_bus;
      rdata_ff <= nxt_rdata;
      wait_ff  <= nxt_wait;
    end
  end

  assign addr_out            = addr_ff;
  assign sport_irq_out       = spirq_ff;
  assign irq_out             = irq_ff;
  assign avs_readdata_out    = rdata_ff;
  assign avs_waitrequest_out = wait_ff;

  // Access view for the checks, so that history is kept on plain signals
  logic [2:0]        chk_idx;  // Pointer index of this cycle's request
  logic [ADDR_W-1:0] chk_ptr;  // Selected pointer before its update
  logic [ADDR_W-1:0] chk_lin;  // Selected pointer plus selected step
  assign chk_idx = {req_in.gen2, req_in.ptr};
  assign chk_ptr = ptr_ff[chk_idx];
  assign chk_lin = ptr_ff[chk_idx] + step_ff[{req_in.gen2, req_in.step}];

  // Bus request taken while the slave is idle
  sequence s_bus_taken;
    (avs_read_in || avs_write_in) && bus_ff == CBAG_IDLE;
  endsequence
  // One answer cycle with waitrequest low, then waiting again
  sequence s_bus_answer;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  // Issued address follows the request and mode one cycle later
  a_second_gen_normal: assert property (@(posedge ref_clk_in) disable iff (srst_in)  // [R8]
    req_in.valid && req_in.gen2 |=> addr_out.addr == $past(chk_ptr))
    else $error("second generator address reversed");
  a_rev_output: assert property (@(posedge ref_clk_in) disable iff (srst_in)  // [R10]
    req_in.valid && !req_in.gen2 && ctrl_ff[CTRL_BITREV_BIT]
    |=> addr_out.addr == bit_rev($past(chk_ptr)))
    else $error("first generator address not reversed");
  a_rev_mirror: assert property (@(posedge ref_clk_in) disable iff (srst_in)  // [R9]
    bit_rev(14'h0001) == 14'h2000 && bit_rev(14'h0040) == 14'h0080)
    else $error("mirror point wrong");
  a_linear_update: assert property (@(posedge ref_clk_in) disable iff (srst_in)  // [R15]
    req_in.valid && len_ff[chk_idx] == 14'h0000 && !(avs_write_in && bus_ff == CBAG_IDLE)
    |=> ptr_ff[$past(chk_idx)] == $past(chk_lin))
    else $error("linear update wrong");
  a_writeback_order: assert property (@(posedge ref_clk_in) disable iff (srst_in)  // [R11]
    req_in.valid && !req_in.gen2 && ctrl_ff[CTRL_BITREV_BIT]
    && len_ff[chk_idx] == 14'h0000 && !(avs_write_in && bus_ff == CBAG_IDLE)
    |=> ptr_ff[$past(chk_idx)] == $past(chk_lin))
    else $error("reversed pointer written back");
  a_modulo_range: assert property (@(posedge ref_clk_in) disable iff (srst_in)  // [R1]
    req_in.valid && len_ff[chk_idx] == 14'h0003 && chk_ptr == 14'h0006
    && step_ff[{req_in.gen2, req_in.step}] == 14'h0001
    && !(avs_write_in && bus_ff == CBAG_IDLE)
    |=> ptr_ff[$past(chk_idx)] == 14'h0004)
    else $error("modulo wrap wrong");
  a_dec_wrap: assert property (@(posedge ref_clk_in) disable iff (srst_in)  // [R6]
    post_mod(14'h0004, 14'h3fff, 14'h0003) == 15'h4006)
    else $error("decrement wrap wrong");
  a_wrap_irq: assert property (@(posedge ref_clk_in) disable iff (srst_in)  // [R7]
    sport_irq_out |-> stat_ff && $past(ctrl_ff[CTRL_SPORT_BIT]))
    else $error("serial wrap event lost");
  a_irq_level: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    irq_out == (stat_ff && mask_ff))
    else $error("interrupt level wrong");
  a_bus_answer: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    s_bus_taken |=> s_bus_answer)
    else $error("bus answer timing wrong");

endmodule // cbag_top

// ---- sim/cbag_ctl_model.sv ----
// Instruction-control side model: issues indirect accesses and watches the address bus
`timescale 1ns/100ps

module cbag_ctl_model
  import cbag_pkg::*;
(
  input  wire logic       clk_in,   // Processor clock
  output cbag_req_t       req_out,  // Access request to the generator
  input  wire cbag_addr_t addr_in,  // Issued address bus
  input  wire logic       sport_in  // Serial wrap pulse
);

  // Quiet request lines from time zero
  initial begin
    req_out = '0;
  end

  // One access; the caller keeps step magnitude below length
  task automatic issue(input logic g, input logic [1:0] p, input logic [1:0] s,
                       output logic [13:0] a, output logic sp, output bit ok);
    ok = 0;
    a  = '0;
    sp = 1'b0;
    @(posedge clk_in);
    req_out <= '{valid: 1'b1, gen2: g, ptr: p, step: s};
    @(posedge clk_in);
    req_out.valid <= 1'b0;
    // Pulses last one cycle, so look once per cycle at mid-period
    for (int k = 0; k < 4 && !ok; k++) begin
      @(negedge clk_in);
      if (addr_in.valid === 1'b1) begin
        ok = 1;
        a  = addr_in.addr;
        sp = sport_in;
      end
    end
  endtask

endmodule // cbag_ctl_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the circular and bit-reverse address generator
`timescale 1ns/100ps

module tb_top
  import cbag_pkg::*;
;
  logic        ref_clk_in;   // Clock
  logic        srst_in;      // Reset
  cbag_req_t   req_in;       // Request from model
  cbag_addr_t  addr_out;     // Address bus
  logic        sport_irq_out;
  logic        irq_out;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  int          num_errors;   // Mismatches
  int          compares;     // Comparisons made
  logic [31:0] seed;         // Random state
  logic [31:0] q;            // Read result
  logic        rev_on;       // Mirror of reverse bit
  logic        sport_on;     // Mirror of serial bit

  cbag_top dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .req_in(req_in),
    .addr_out(addr_out), .sport_irq_out(sport_irq_out), .irq_out(irq_out),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out));

  cbag_ctl_model ctl (.clk_in(ref_clk_in), .req_out(req_in), .addr_in(addr_out),
    .sport_in(sport_irq_out));

  // Clock at 4 ns period
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // Verdict and end of run
  task automatic close_out();
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Word comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  // Flag comparison
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected next pointer with wrap flag on top
  function automatic logic [14:0] nxt_ptr(input logic [13:0] i, m, l);
    int n, b, s;
    if (l == 0) return {1'b0, i + m};
    n = 0;
    while ((1 << n) < l) n++;
    b = int'(i) & ~((1 << n) - 1);
    s = int'(i) + int'($signed(m)) - b;
    if (s < 0) return {1'b1, 14'(s + l + b)};
    if (s >= int'(l)) return {1'b1, 14'(s - l + b)};
    return {1'b0, 14'(s + b)};
  endfunction

  // Mirror about the bit 6/7 midpoint
  function automatic logic [13:0] rev(input logic [13:0] a);
    for (int k = 0; k < 14; k++) rev[k] = a[13-k];
  endfunction

  // One Avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge ref_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    for (int k = 0; k < 16 && !done; k++) begin
      @(posedge ref_clk_in);
      if (avs_waitrequest_out === 1'b0) begin
        done = 1;
        q    = avs_readdata_out;
      end
    end
    if (!done) chk_bit(1'b1, 1'b0);
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  // Load a pointer set, run accesses, check addresses, wrap pulses and write-back
  task automatic run(input logic g, input logic [1:0] p, s,
                     input logic [13:0] i, m, l, input int cnt);
    logic [7:0]  o;
    logic [14:0] e;
    logic [13:0] a;
    logic        sp;
    bit          ok;
    o = g ? OFS_PTR4 : OFS_PTR0;
    bus(1, o + 8'(4 * p), {18'h0, i});
    bus(1, o + 8'h10 + 8'(4 * s), {18'h0, m});
    bus(1, o + 8'h20 + 8'(4 * p), {18'h0, l});
    repeat (cnt) begin
      ctl.issue(g, p, s, a, sp, ok);
      e = nxt_ptr(i, m, l);
      chk_bit(ok, 1'b1);
      chk({18'h0, a}, {18'h0, (rev_on && !g) ? rev(i) : i});
      chk_bit(sp, e[14] && sport_on && !g && p == 0);
      i = e[13:0];
    end
    bus(0, o + 8'(4 * p), '0);
    chk(q, {18'h0, i});
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    num_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [13:0] ln, st, bs;
    num_errors = 0;
    compares = 0;
    seed = 32'hbc7c;
    rev_on = 0;
    sport_on = 0;
    srst_in = 1'b1;
    avs_address_in = '0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = '0;
    repeat (4) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    bus(0, OFS_CTRL, '0);
    chk(q, 32'h0);
    bus(0, OFS_LEN0 + 8'h0c, '0);
    chk(q, 32'h0);
    bus(1, 8'h80, 32'h0000_1234);
    bus(0, 8'h80, '0);
    chk(q, RD_ZERO);
    run(0, 0, 0, 14'h0005, 14'h0001, 14'h0003, 5);
    run(0, 1, 1, 14'h0005, 14'h3fff, 14'h0003, 5);
    bus(0, OFS_STEP0 + 8'h04, '0);
    chk(q, 32'hffff_ffff);
    run(1, 2, 3, 14'h0009, 14'h0003, 14'h0005, 6);
    run(1, 3, 2, 14'h3ffe, 14'h0002, 14'h0000, 3);
    // Random buffers on both generators, random select pairings over twelve runs
    for (int t = 0; t < 12; t++) begin
      seed = lfsr(seed);
      ln = 14'(seed[3:0] + 1);
      seed = lfsr(seed);
      st = 14'(int'(seed[7:0] % (2 * ln - 1)) - int'(ln) + 1);
      bs = seed[21:8] & ~14'h000f;
      run(seed[30], seed[25:24], seed[27:26], bs + 14'(seed[31:28] % ln), st, ln, 4);
    end
    rev_on = 1;
    bus(1, OFS_CTRL, 32'h1);
    run(0, 3, 2, 14'h0001, 14'h0001, 14'h0000, 3);
    run(0, 1, 0, 14'h0000, 14'h0800, 14'h0000, 8);
    run(1, 0, 0, 14'h0001, 14'h0001, 14'h0000, 2);
    rev_on = 0;
    bus(1, OFS_CTRL, 32'h0);
    run(0, 3, 2, 14'h0040, 14'h0001, 14'h0000, 2);
    bus(0, OFS_LAST, '0);
    chk(q, 32'h0000_0041);
    bus(0, OFS_LAST + 8'h04, '0);
    chk(q, 32'h0000_0002);
    sport_on = 1;
    bus(1, OFS_CTRL, 32'h2);
    bus(1, OFS_MASK, 32'h1);
    run(0, 0, 0, 14'h0006, 14'h0001, 14'h0003, 2);
    repeat (3) @(posedge ref_clk_in);
    chk_bit(irq_out, 1'b1);
    bus(0, OFS_STATUS, '0);
    chk(q, 32'h1);
    repeat (3) @(posedge ref_clk_in);
    chk_bit(irq_out, 1'b0);
    bus(0, OFS_STATUS, '0);
    chk(q, 32'h0);
    close_out();
  end

endmodule // tb_top
